//--- ecr_card.sv
// Read-side bus logic of the eight-socket EPROM card
`timescale 1ns/1ps
module ecr_card
  import ecr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] addr_hi,
  input wire logic [BASE_W-1:0] base_switch,
  input wire logic mem_read,
  input wire logic examine,
  input wire logic protect_write_switch,
  input wire logic wait_request,
  input wire logic wait_jumper,
  input wire logic prog_active,
  input wire logic [DATA_W-1:0] eprom_data,
  output logic card_select_n,
  output logic [SOCKETS-1:0] eprom_cs_n,
  output logic bank_lo_en,
  output logic bank_hi_en,
  output logic [DATA_W-1:0] data_in_bus,
  output logic data_in_bus_oe_n,
  output logic ps_out,
  output logic ps_oe_n,
  output logic prdy
);
  logic [SYNC_W-1:0] s1_q;
  logic [SYNC_W-1:0] s2_q;
  logic [SYNC_W-1:0] s3_q;
  logic [SYNC_W-1:0] f_q;
  logic [DATA_W-1:0] data_f;
  logic [ADDR_W-1:0] addr_f;
  logic [BASE_W-1:0] base_f;
  logic rd_f;
  logic exam_f;
  logic prot_f;
  logic wreq_f;
  logic jmp_f;
  logic match;
  logic [FILL_DEPTH-1:0] fill_q;
  logic filled;
  logic rd_hit;
  logic rd_hit_q;
  logic card_select_n_q;
  logic [SOCKETS-1:0] cs_n_q;
  logic bank_lo_q;
  logic bank_hi_q;
  logic [DATA_W-1:0] di_q;
  logic di_oe_n_q;
  logic ps_q;
  logic ps_oe_n_q;
  logic prdy_q;
  ecr_wait_e state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] pulse_len_q;

  ecr_dec_if dif ();

  ecr_cs_decoder u_dec (
    .dif(dif)
  );

  // Pin synchroniser; a bit changes once stages two and three agree
  always_ff @(posedge clock) begin
    if (rst) begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
      s3_q <= SYNC_RST;
      f_q <= SYNC_RST;
    end else begin
      s1_q <= {wait_jumper, wait_request, protect_write_switch, examine, mem_read,
               base_switch, addr_hi, eprom_data};
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q <= (s2_q & s3_q) | (f_q & (s2_q ^ s3_q));
    end
  end

  assign data_f = f_q[SY_DATA +: DATA_W];
  assign addr_f = f_q[SY_ADDR +: ADDR_W];
  assign base_f = f_q[SY_BASE +: BASE_W];
  assign rd_f = f_q[SY_RD];
  assign exam_f = f_q[SY_EXAM];
  assign prot_f = f_q[SY_PROT];
  assign wreq_f = f_q[SY_WREQ];
  assign jmp_f = f_q[SY_JMP];

  // Filter is cleared by reset; no compare until it holds real pin levels
  always_ff @(posedge clock) begin
    if (rst) begin
      fill_q <= FILL_RST;
    end else begin
      fill_q <= {fill_q[FILL_DEPTH-2:0], 1'b1};
    end
  end

  assign filled = fill_q[FILL_DEPTH-1];

  // Card window compare against the base switches
  assign match = filled && (addr_f[CARD_LO +: BASE_W] == base_f);
  assign rd_hit = match && rd_f;

  assign dif.sel = addr_f[SOCK_LO +: SOCK_W];
  assign dif.en = match && !prog_active;

  // Board select
  always_ff @(posedge clock) begin
    if (rst) begin
      card_select_n_q <= 1'b1;
    end else begin
      card_select_n_q <= !match;
    end
  end

  // Socket chip selects
  always_ff @(posedge clock) begin
    if (rst) begin
      cs_n_q <= CS_ALL_OFF;
    end else begin
      cs_n_q <= dif.cs_n;
    end
  end

  // Auxiliary supply bank enables
  always_ff @(posedge clock) begin
    if (rst) begin
      bank_lo_q <= 1'b0;
      bank_hi_q <= 1'b0;
    end else begin
      bank_lo_q <= match && !addr_f[BANK_BIT];
      bank_hi_q <= match && addr_f[BANK_BIT];
    end
  end

  // Data-in buffers
  always_ff @(posedge clock) begin
    if (rst) begin
      di_q <= DATA_RST;
      di_oe_n_q <= 1'b1;
    end else begin
      di_q <= data_f;
      di_oe_n_q <= !(match && (rd_f || exam_f));
    end
  end

  // Protect status
  always_ff @(posedge clock) begin
    if (rst) begin
      ps_q <= 1'b0;
      ps_oe_n_q <= 1'b1;
    end else begin
      ps_q <= prot_f;
      ps_oe_n_q <= !match;
    end
  end

  // Optional wait-state pulse, one per read of the card
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q <= CNT_ZERO;
      rd_hit_q <= 1'b0;
    end else begin
      rd_hit_q <= rd_hit;
      case (state_q)
        ST_IDLE: begin
          cnt_q <= CNT_ZERO;
          if (jmp_f && rd_hit && !rd_hit_q) begin
            state_q <= ST_PULSE;
          end
        end
        ST_PULSE: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == WAIT_LAST) begin
            state_q <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          cnt_q <= CNT_ZERO;
          // Hold until the read ends so one read gives one pulse
          if (!rd_hit) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          cnt_q <= CNT_ZERO;
        end
      endcase
    end
  end

  // Ready: inverse of wait request, pulled low during the wait pulse
  always_ff @(posedge clock) begin
    if (rst) begin
      prdy_q <= 1'b1;
    end else begin
      prdy_q <= !(wreq_f || (state_q == ST_PULSE));
    end
  end

  // Length of the current wait pulse, read only by checks
  always_ff @(posedge clock) begin
    if (rst) begin
      pulse_len_q <= CNT_ZERO;
    end else if (state_q == ST_PULSE) begin
      pulse_len_q <= pulse_len_q + 1'b1;
    end else begin
      pulse_len_q <= CNT_ZERO;
    end
  end

  assign card_select_n = card_select_n_q;
  assign eprom_cs_n = cs_n_q;
  assign bank_lo_en = bank_lo_q;
  assign bank_hi_en = bank_hi_q;
  assign data_in_bus = di_q;
  assign data_in_bus_oe_n = di_oe_n_q;
  assign ps_out = ps_q;
  assign ps_oe_n = ps_oe_n_q;
  assign prdy = prdy_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  card_sel_a: assert property (
    card_select_n_q == !($past(filled)
      && ($past(addr_f[CARD_LO +: BASE_W]) == $past(base_f))))
    else $error("board select does not follow the address compare");

  cs_onehot_a: assert property ($onehot0(~cs_n_q))
    else $error("more than one socket select low");

  cs_match_a: assert property (
    (!card_select_n_q && !$past(prog_active)) |->
      (cs_n_q == ~(8'h01 << $past(addr_f[SOCK_LO +: SOCK_W]))))
    else $error("wrong socket selected");

  cs_gate_a: assert property (($past(prog_active) || card_select_n_q) |-> &cs_n_q)
    else $error("socket select active during programming or deselect");

  bank_sel_a: assert property (
    !card_select_n_q |-> (bank_hi_en == $past(addr_f[BANK_BIT]))
      && (bank_lo_en == !$past(addr_f[BANK_BIT])))
    else $error("bank enable does not follow A12");

  bank_off_a: assert property (card_select_n_q |-> !bank_lo_en && !bank_hi_en)
    else $error("bank enabled while card deselected");

  di_en_a: assert property (
    !data_in_bus_oe_n |-> !card_select_n_q && ($past(rd_f) || $past(exam_f)))
    else $error("data-in enabled without select and read");

  di_pass_a: assert property (!data_in_bus_oe_n |-> data_in_bus == $past(data_f))
    else $error("data-in does not pass EPROM data");

  ps_drive_a: assert property (ps_oe_n == card_select_n_q)
    else $error("protect status drive wrong");

  ps_value_a: assert property (!ps_oe_n |-> ps_out == $past(prot_f))
    else $error("protect status value wrong");

  prdy_lvl_a: assert property (
    (state_q != ST_PULSE) |=> prdy_q == !$past(wreq_f))
    else $error("ready does not mirror wait request");

  pulse_len_a: assert property (
    (state_q == ST_PULSE) && (pulse_len_q == WAIT_LAST) |=> state_q == ST_HOLD)
    else $error("wait pulse length wrong");

  rst_out_a: assert property (
    $past(rst) |-> card_select_n_q && (&cs_n_q) && data_in_bus_oe_n && ps_oe_n
      && !bank_lo_en && !bank_hi_en)
    else $error("outputs active after reset");

  wait_pulse_c: cover property ($rose(state_q == ST_PULSE));
  top_sock_c: cover property (!cs_n_q[SOCKETS-1]);
  read_c: cover property (!data_in_bus_oe_n && !ps_oe_n);
endmodule : ecr_card

//--- ecr_pkg.sv
// Constants and types shared by the EPROM card read-side logic
// What this block does
// - Base address comes from three switches; all set places card at 56K.
// - Board select goes low only when A15..A13 match switches; high after reset.
// - A12..A10 pick one of eight sockets inside the 8K window.
// - Exactly one select low per 1K step, never two; all high at reset.
// - Socket select low while its block is accessed, high otherwise.
// - Chip selects are gated off while a programming cycle runs.
// - Supply bank enables follow A12 while the card is selected.
// - Lower enable feeds sockets zero to three, upper feeds four to seven.
// - Data-in buffers pass EPROM bits uninverted when enabled, else float.
// - Data-in enable needs board select and a memory read or examine.
// - Protect status is driven only while the card is selected.
// - Protect status low in protect position, high in write position.
// - Ready is the inverse of wait request; released high when idle.
// - With wait jumper fitted, each read gives one 500 ns ready low pulse.
package ecr_pkg;
  localparam int CLK_NS = 50;
  localparam int WAIT_PULSE_NS = 500;
  localparam int WAIT_CYC = (WAIT_PULSE_NS / CLK_NS < 1) ? 1 : WAIT_PULSE_NS / CLK_NS;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] WAIT_LAST = CNT_W'(WAIT_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 6;
  localparam int BASE_W = 3;
  localparam int SOCKETS = 8;
  localparam int SOCK_W = 3;
  // Positions within the sampled A15..A10 field
  localparam int CARD_LO = 3;
  localparam int SOCK_LO = 0;
  localparam int BANK_BIT = 2;

  // Layout of the synchronised pin vector
  localparam int SY_DATA = 0;
  localparam int SY_ADDR = SY_DATA + DATA_W;
  localparam int SY_BASE = SY_ADDR + ADDR_W;
  localparam int SY_RD = SY_BASE + BASE_W;
  localparam int SY_EXAM = SY_RD + 1;
  localparam int SY_PROT = SY_EXAM + 1;
  localparam int SY_WREQ = SY_PROT + 1;
  localparam int SY_JMP = SY_WREQ + 1;
  localparam int SYNC_W = SY_JMP + 1;
  localparam logic [SYNC_W-1:0] SYNC_RST = '0;
  // Edges after reset before the filtered pins hold live levels
  localparam int FILL_DEPTH = 4;
  localparam logic [FILL_DEPTH-1:0] FILL_RST = '0;

  localparam logic [SOCKETS-1:0] CS_ALL_OFF = 8'hFF;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_PULSE = 3'h2,
    ST_HOLD = 3'h4
  } ecr_wait_e;
endpackage : ecr_pkg

//--- ecr_dec_if.sv
// Carrier between the card top and its socket decoder
`timescale 1ns/1ps
interface ecr_dec_if;
  import ecr_pkg::*;
  logic [SOCK_W-1:0] sel;
  logic en;
  logic [SOCKETS-1:0] cs_n;
  modport host (output sel, output en, input cs_n);
  modport dec (input sel, input en, output cs_n);
endinterface : ecr_dec_if

//--- ecr_cs_decoder.sv
// One-of-eight socket select decoder
`timescale 1ns/1ps
module ecr_cs_decoder
  import ecr_pkg::*;
(
  ecr_dec_if.dec dif
);
  genvar i;
  generate
    for (i = 0; i < SOCKETS; i++) begin : g_sock
      // Low only for the addressed socket while enabled
      assign dif.cs_n[i] = !(dif.en && (dif.sel == SOCK_W'(i)));
    end
  endgenerate
endmodule : ecr_cs_decoder

//--- ecr_bus_master.sv
// Bus master model: runs read cycles and stalls on ready
`timescale 1ns/1ps
module ecr_bus_master
  import ecr_pkg::*;
(
  input wire logic clock,
  input wire logic start,
  input wire logic prdy,
  output logic mem_read,
  output logic busy,
  output logic [7:0] stall_cnt
);
  initial begin
    mem_read = 1'b0;
    busy = 1'b0;
    stall_cnt = 8'h00;
    forever begin
      @(posedge clock);
      if (start && !busy) begin
        @(negedge clock);
        busy = 1'b1;
        mem_read = 1'b1;
        stall_cnt = 8'h00;
        repeat (8) @(negedge clock);
        while (prdy !== 1'b1) begin
          stall_cnt = stall_cnt + 8'h01;
          @(negedge clock);
        end
        mem_read = 1'b0;
        busy = 1'b0;
      end
    end
  end
endmodule : ecr_bus_master

//--- test_eprom_card_read_decode.sv
// Self-checking bench for the EPROM card read-side logic
`timescale 1ns/1ps
module test_eprom_card_read_decode
  import ecr_pkg::*;
;
  logic clock = 1'b0, rst = 1'b1, exam = 1'b1, pws = 1'b0;
  logic wreq = 1'b0, jmp = 1'b0, prog = 1'b0, start = 1'b0;
  logic [ADDR_W-1:0] addr = 6'h38;
  logic [BASE_W-1:0] base = 3'h7;
  logic [DATA_W-1:0] edat = 8'h00, dib;
  logic rd, busy, bsel_n, b_lo, b_hi, oe_n, ps, ps_oe_n, prdy;
  logic [SOCKETS-1:0] cs_n;
  logic [7:0] stall;
  logic [DATA_W-1:0] bus;
  int failures = 0, checks = 0, cycles = 0, low_cnt = 0;
  localparam int PROG_RECOVER_CYC = 10000 / CLK_NS;
  assign bus = oe_n ? 8'hFF : dib;
  always #25 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (prdy === 1'b0) low_cnt <= low_cnt + 1;
    if (cycles == 3000) begin
      failures++;
      close_out();
    end
  end
  ecr_bus_master mst (.clock(clock), .start(start), .prdy(prdy), .mem_read(rd),
    .busy(busy), .stall_cnt(stall));
  ecr_card uut (.clock(clock), .rst(rst), .addr_hi(addr), .base_switch(base),
    .mem_read(rd), .examine(exam), .protect_write_switch(pws), .wait_request(wreq),
    .wait_jumper(jmp), .prog_active(prog), .eprom_data(edat), .card_select_n(bsel_n),
    .eprom_cs_n(cs_n), .bank_lo_en(b_lo), .bank_hi_en(b_hi), .data_in_bus(dib),
    .data_in_bus_oe_n(oe_n), .ps_out(ps), .ps_oe_n(ps_oe_n), .prdy(prdy));
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic settle();
    repeat (7) @(negedge clock);
  endtask : settle
  task automatic idle_outs(input logic lo);
    chk("bsel_n", 8'h01, bsel_n);
    chk("cs_n", CS_ALL_OFF, cs_n);
    chk("bank", 8'h00, {b_hi, b_lo});
    chk("oe_n", 8'h01, oe_n);
    chk("bus", 8'hFF, bus);
    chk("ps_oe_n", 8'h01, ps_oe_n);
    if (lo) chk("prdy", 8'h01, prdy);
  endtask : idle_outs
  task automatic t_reset(input int hold);
    addr = 6'h00;
    rst = 1'b1;
    repeat (hold) @(negedge clock);
    idle_outs(1'b1);
    rst = 1'b0;
    repeat (6) begin
      @(negedge clock);
      chk("bsel_n", 8'h01, bsel_n);
      chk("cs_n", CS_ALL_OFF, cs_n);
    end
    $display("test reset done");
  endtask : t_reset
  task automatic t_sweep();
    for (int i = 0; i < SOCKETS; i++) begin
      addr = {3'h7, 3'(i)};
      edat = 8'h5A ^ 8'(i);
      pws = i[0];
      settle();
      chk("bsel_n", 8'h00, bsel_n);
      chk("cs_n", ~(8'h01 << i), cs_n);
      chk("lo", 8'(i < 4), b_lo);
      chk("hi", 8'(i >= 4), b_hi);
      chk("bus", edat, bus);
      chk("ps_oe_n", 8'h00, ps_oe_n);
      chk("ps", 8'(pws), ps);
    end
    exam = 1'b0;
    settle();
    chk("oe_n", 8'h01, oe_n);
    $display("test sweep done");
  endtask : t_sweep
  task automatic t_foreign();
    exam = 1'b1;
    base = 3'h3;
    settle();
    idle_outs(1'b0);
    base = 3'h7;
    $display("test foreign done");
  endtask : t_foreign
  task automatic t_prog();
    addr = 6'h39;
    settle();
    prog = 1'b1;
    repeat (2) @(negedge clock);
    chk("cs_n", CS_ALL_OFF, cs_n);
    prog = 1'b0;
    repeat (PROG_RECOVER_CYC) @(negedge clock);
    chk("cs_n", 8'hFD, cs_n);
    chk("bus", edat, bus);
    $display("test prog done");
  endtask : t_prog
  task automatic t_wait();
    wreq = 1'b1;
    settle();
    chk("prdy", 8'h00, prdy);
    wreq = 1'b0;
    settle();
    chk("prdy", 8'h01, prdy);
    $display("test wait done");
  endtask : t_wait
  task automatic t_read(input logic [ADDR_W-1:0] a);
    int n;
    int lo0;
    exam = 1'b0;
    jmp = 1'b1;
    addr = a;
    settle();
    lo0 = low_cnt;
    start = 1'b1;
    @(negedge clock);
    start = 1'b0;
    @(negedge clock);
    n = 0;
    while (busy && n < 200) begin
      @(negedge clock);
      n++;
    end
    chk("done", 8'h00, 8'(busy));
    settle();
    chk("pulse", 8'(WAIT_CYC), 8'(low_cnt - lo0));
    chk("stall", 8'h01, 8'(stall != 8'h00));
    chk("oe_n", 8'h01, oe_n);
    $display("test read done");
  endtask : t_read
  task automatic close_out();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  initial begin
    t_reset(16);
    t_sweep();
    t_foreign();
    t_prog();
    t_wait();
    t_reset(2);
    t_read(6'h38);
    t_read(6'h3F);
    close_out();
  end
endmodule : test_eprom_card_read_decode
